// File: design/hbr_pkg.sv
// holds the constants of the host bus reset and system pin block
// assumes one 40 MHz bus clock and a 32-bit shared address/data bus
package hbr_pkg;
	// ****************************************
	// bus widths
	// ****************************************
	localparam int unsigned AD_W = 32;
	localparam int unsigned CBE_W = 4;
	localparam int unsigned IDX_W = 2;
	localparam int unsigned IDX_LSB = 2;
	localparam int unsigned DEC_LSB = 8;
	// ****************************************
	// decode window, arbitrary default
	// ****************************************
	localparam logic [AD_W-1:DEC_LSB] BASE_HI = 24'h00F000;
	// ****************************************
	// bus commands
	// ****************************************
	localparam logic [CBE_W-1:0] CMD_MEM_RD = 4'h6;
	localparam logic [CBE_W-1:0] CMD_MEM_WR = 4'h7;
	// ****************************************
	// register indices
	// ****************************************
	localparam logic [IDX_W-1:0] IDX_CTRL = 2'h0;
	localparam logic [IDX_W-1:0] IDX_STAT = 2'h1;
	localparam logic [IDX_W-1:0] IDX_PM = 2'h2;
	localparam logic [IDX_W-1:0] IDX_VEND = 2'h3;
	// ****************************************
	// field positions
	// ****************************************
	localparam int unsigned CTRL_IE_BIT = 0;
	localparam int unsigned STAT_EV_BIT = 0;
	// ****************************************
	// reset values and address step
	// ****************************************
	localparam logic [AD_W-1:0] CTRL_RST = 32'h00000000;
	localparam logic [AD_W-1:0] PM_RST = 32'h00000000;
	localparam logic [AD_W-1:0] VEND_RST = 32'h00000000;
	localparam logic [AD_W-1:0] ADDR_STEP = 32'h00000004;
	// ****************************************
	// target states
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_DEC,
		ST_XFER,
		ST_TURN
	} hbr_state_e;
endpackage : hbr_pkg

// File: design/hbr_top.sv
// holds the host bus target with two-scope reset and interrupt pin
// assumes all bus inputs are synchronous to clk_in, resets active low
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - global power reset returns every register, kept ones too, to defaults
// - while global reset is held, the block does nothing at all
// - while bus reset is held, every output enable is low
// - bus reset clears all registers except power context and vendor bits
// - while bus reset is held, the block does nothing at all
// - all bus signals sampled on rising clock edge; timing from that clock
// - interrupt leaves on its own open-drain pin, pulling low only
// - address phase carries a 32-bit address on the shared lines
// - data phase carries the data word on the shared lines
module hbr_top (
	// clock and resets
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic bus_resetn_in,
	// shared address/data lines
	input wire logic [hbr_pkg::AD_W-1:0] shared_addr_data_in,
	output logic [hbr_pkg::AD_W-1:0] shared_addr_data_out,
	output logic shared_addr_data_oe_out,
	// command and handshake
	input wire logic [hbr_pkg::CBE_W-1:0] cbe_n_in,
	input wire logic frame_n_in,
	input wire logic irdy_n_in,
	output logic trdy_n_out,
	output logic trdy_oe_out,
	output logic devsel_n_out,
	output logic devsel_oe_out,
	// interrupt source and pin
	input wire logic event_in,
	output logic host_interrupt_line_out,
	output logic host_interrupt_line_oe_out
);
	import hbr_pkg::*;

	// ****************************************
	// reset scope
	// ****************************************
	logic glob_rst;
	logic any_rst;
	assign glob_rst = ~resetn_in;
	assign any_rst = glob_rst | ~bus_resetn_in;

	// ****************************************
	// state
	// ****************************************
	hbr_state_e state_r;
	hbr_state_e state_nxt;
	logic [AD_W-1:0] addr_r;
	logic wr_r;
	logic [AD_W-1:0] rdata_r;
	logic [AD_W-1:0] ctrl_r;
	logic stat_ev_r;
	logic [AD_W-1:0] pm_r;
	logic [AD_W-1:0] vend_r;
	logic hit;
	logic cmd_ok;
	logic beat;
	logic wr_beat;
	logic [AD_W-1:0] addr_nxt;
	logic [IDX_W-1:0] idx_nxt;

	// ****************************************
	// decode and handshake
	// ****************************************
	// address phase: shared lines hold the target address
	assign hit = (shared_addr_data_in[AD_W-1:DEC_LSB] == BASE_HI);
	assign cmd_ok = (~cbe_n_in == CMD_MEM_RD) || (~cbe_n_in == CMD_MEM_WR);
	// a data phase completes on an edge with both readies low
	assign beat = (state_r == ST_XFER) && ~irdy_n_in;
	assign wr_beat = beat && wr_r;
	assign addr_nxt = addr_r + ADDR_STEP;
	assign idx_nxt = addr_nxt[IDX_LSB +: IDX_W];

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (~frame_n_in && hit && cmd_ok) begin
					state_nxt = ST_DEC;
				end
			end
			ST_DEC: begin
				state_nxt = ST_XFER;
			end
			ST_XFER: begin
				if (beat && frame_n_in) begin
					state_nxt = ST_TURN;
				end
			end
			ST_TURN: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (any_rst) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ****************************************
	// address and direction capture
	// ****************************************
	always_ff @(posedge clk_in) begin
		if (any_rst) begin
			addr_r <= '0;
			wr_r <= 1'b0;
		end else if (state_r == ST_IDLE && state_nxt == ST_DEC) begin
			addr_r <= shared_addr_data_in;
			wr_r <= (~cbe_n_in == CMD_MEM_WR);
		end else if (beat) begin
			addr_r <= addr_nxt;
		end
	end

	// ****************************************
	// read data
	// ****************************************
	function automatic logic [AD_W-1:0] rd_sel(
		input logic [IDX_W-1:0] idx,
		input logic [AD_W-1:0] c,
		input logic ev,
		input logic [AD_W-1:0] p,
		input logic [AD_W-1:0] v
	);
		logic [AD_W-1:0] r;
		r = '0;
		case (idx)
			IDX_CTRL: r = c;
			IDX_STAT: r[STAT_EV_BIT] = ev;
			IDX_PM: r = p;
			IDX_VEND: r = v;
			default: r = '0;
		endcase
		return r;
	endfunction : rd_sel

	always_ff @(posedge clk_in) begin
		if (any_rst) begin
			rdata_r <= '0;
		end else if (state_r == ST_DEC) begin
			rdata_r <= rd_sel(addr_r[IDX_LSB +: IDX_W], ctrl_r, stat_ev_r,
				pm_r, vend_r);
		end else if (beat) begin
			rdata_r <= rd_sel(idx_nxt, ctrl_r, stat_ev_r, pm_r, vend_r);
		end
	end

	// ****************************************
	// registers cleared by either reset
	// ****************************************
	always_ff @(posedge clk_in) begin
		if (any_rst) begin
			ctrl_r <= CTRL_RST;
		end else if (wr_beat && addr_r[IDX_LSB +: IDX_W] == IDX_CTRL) begin
			ctrl_r <= shared_addr_data_in;
		end
	end

	// event flag: write one to clear, a new event wins
	always_ff @(posedge clk_in) begin
		if (any_rst) begin
			stat_ev_r <= 1'b0;
		end else if (event_in) begin
			stat_ev_r <= 1'b1;
		end else if (wr_beat && addr_r[IDX_LSB +: IDX_W] == IDX_STAT &&
			shared_addr_data_in[STAT_EV_BIT]) begin
			stat_ev_r <= 1'b0;
		end
	end

	// ****************************************
	// registers kept over bus reset
	// ****************************************
	always_ff @(posedge clk_in) begin
		if (glob_rst) begin
			pm_r <= PM_RST;
		end else if (~any_rst && wr_beat &&
			addr_r[IDX_LSB +: IDX_W] == IDX_PM) begin
			pm_r <= shared_addr_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (glob_rst) begin
			vend_r <= VEND_RST;
		end else if (~any_rst && wr_beat &&
			addr_r[IDX_LSB +: IDX_W] == IDX_VEND) begin
			vend_r <= shared_addr_data_in;
		end
	end

	// ****************************************
	// pin drivers
	// ****************************************
	logic active;
	logic rd_drive;
	assign active = (state_r == ST_XFER);
	assign rd_drive = active && ~wr_r;

	// data phase: shared lines carry the read word
	assign shared_addr_data_out = rdata_r;
	assign shared_addr_data_oe_out = rd_drive && ~any_rst;
	assign trdy_n_out = ~active;
	assign trdy_oe_out = (active || state_r == ST_TURN) && ~any_rst;
	assign devsel_n_out = ~active;
	assign devsel_oe_out = (active || state_r == ST_TURN) && ~any_rst;

	// interrupt pin only ever pulls low
	assign host_interrupt_line_out = 1'b0;
	assign host_interrupt_line_oe_out = stat_ev_r && ctrl_r[CTRL_IE_BIT] &&
		~any_rst;
endmodule : hbr_top

`default_nettype wire

// File: tb/hbr_host.sv
// model of the host bus initiator
// assumes the target answers on the shared lines when its oe is high
`timescale 1ns/100ps
`default_nettype none
module hbr_host (
	// clock
	input wire logic clk_in,
	// to the target
	output logic [hbr_pkg::AD_W-1:0] ad_out,
	output logic [hbr_pkg::CBE_W-1:0] cbe_n_out,
	output logic frame_n_out,
	output logic irdy_n_out,
	// from the target
	input wire logic [hbr_pkg::AD_W-1:0] ad_in,
	input wire logic ad_oe_in,
	input wire logic trdy_n_in
);
	import hbr_pkg::*;
	// ********
	// one transfer
	// ********
	logic [AD_W-1:0] ad_r = '0;
	assign ad_out = ad_oe_in ? ad_in : ad_r;
	initial begin
		cbe_n_out = 4'hF;
		frame_n_out = 1'b1;
		irdy_n_out = 1'b1;
	end
	task automatic xfer(input logic wr, input logic [AD_W-1:0] a,
		input logic [AD_W-1:0] d, input int waits,
		output logic [AD_W-1:0] q, output logic ok);
		logic hit;
		ok = 1'b0;
		@(posedge clk_in);
		#2;
		frame_n_out = 1'b0;
		ad_r = a;
		cbe_n_out = wr ? 4'h8 : 4'h9;
		@(posedge clk_in);
		#2;
		frame_n_out = 1'b1;
		cbe_n_out = 4'h0;
		ad_r = wr ? d : ~a;
		irdy_n_out = waits > 0;
		for (int i = 0; i < 10 && !ok; i++) begin
			@(negedge clk_in);
			hit = !trdy_n_in && !irdy_n_out;
			q = ad_out;
			@(posedge clk_in);
			#2;
			ok = hit;
			if (!ok && i + 1 >= waits) irdy_n_out = 1'b0;
		end
		irdy_n_out = 1'b1;
		ad_r = ~ad_r;
	endtask : xfer
endmodule : hbr_host
`default_nettype wire

// File: tb/hbr_top_asserts.sv
// checker of the host bus target pins
// assumes it is bound into hbr_top, one clock
`timescale 1ns/100ps
`default_nettype none
module hbr_asserts (
	// clock and resets
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic bus_resetn_in,
	// bus
	input wire logic [hbr_pkg::AD_W-1:0] shared_addr_data_in,
	input wire logic shared_addr_data_oe_out,
	input wire logic [hbr_pkg::CBE_W-1:0] cbe_n_in,
	input wire logic frame_n_in,
	input wire logic irdy_n_in,
	input wire logic trdy_n_out,
	input wire logic trdy_oe_out,
	input wire logic devsel_n_out,
	input wire logic devsel_oe_out,
	// interrupt
	input wire logic host_interrupt_line_out,
	input wire logic host_interrupt_line_oe_out
);
	import hbr_pkg::*;
	// ********
	// properties
	// ********
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in || !bus_resetn_in);
	sequence s_hit;
		$fell(frame_n_in) && (cbe_n_in == 4'h9 || cbe_n_in == 4'h8)
		&& shared_addr_data_in[AD_W-1:DEC_LSB] == BASE_HI;
	endsequence
	sequence s_last;
		!trdy_n_out && trdy_oe_out && !irdy_n_in && frame_n_in;
	endsequence
	a_oe_bus_rst: assert property (disable iff (!resetn_in)
		!bus_resetn_in |-> !(trdy_oe_out | shared_addr_data_oe_out
		| devsel_oe_out | host_interrupt_line_oe_out))
		else $error("oe in bus reset");
	a_claim_delay: assert property (s_hit |-> ##1 !trdy_oe_out
		##1 (!trdy_n_out && trdy_oe_out)) else $error("claim late");
	a_miss_quiet: assert property ($fell(frame_n_in)
		&& shared_addr_data_in[AD_W-1:DEC_LSB] != BASE_HI
		|-> ##1 !trdy_oe_out [*3]) else $error("miss claimed");
	a_turn_release: assert property (s_last |=>
		trdy_oe_out && trdy_n_out ##1 !trdy_oe_out) else $error("no turn");
	a_turn_idle: assert property (trdy_oe_out && trdy_n_out
		|=> !trdy_oe_out [*2]) else $error("turn too long");
	a_trdy_waits: assert property (!trdy_n_out && trdy_oe_out
		&& irdy_n_in |=> !trdy_n_out) else $error("trdy dropped");
	a_data_xfer: assert property (shared_addr_data_oe_out
		|-> !trdy_n_out && trdy_oe_out) else $error("data outside xfer");
	a_int_low: assert property (host_interrupt_line_out == 1'b0)
		else $error("interrupt driven high");
	a_devsel_follow: assert property (devsel_n_out == trdy_n_out
		&& devsel_oe_out == trdy_oe_out) else $error("devsel apart from trdy");
endmodule : hbr_asserts
bind hbr_top hbr_asserts chk (.clk_in, .resetn_in, .bus_resetn_in,
	.shared_addr_data_in, .shared_addr_data_oe_out, .cbe_n_in,
	.frame_n_in, .irdy_n_in, .trdy_n_out, .trdy_oe_out,
	.devsel_n_out, .devsel_oe_out,
	.host_interrupt_line_out, .host_interrupt_line_oe_out);
`default_nettype wire

// File: tb/tb_hbr_top.sv
// testbench of hbr_top with an initiator model
// assumes hbr_pkg, hbr_host and the checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_hbr_top;
	import hbr_pkg::*;
	// ********
	// bench
	// ********
	logic clk_in = 1'b0;
	logic resetn_in, bus_resetn_in, event_in, ok;
	logic [AD_W-1:0] shared_addr_data_in, shared_addr_data_out, q;
	logic [CBE_W-1:0] cbe_n_in;
	logic frame_n_in, irdy_n_in, trdy_n_out, trdy_oe_out, devsel_n_out;
	logic devsel_oe_out, shared_addr_data_oe_out;
	logic host_interrupt_line_out, host_interrupt_line_oe_out;
	int n_fail = 0;
	int n_checks = 0;
	always #12.5 clk_in = ~clk_in;
	hbr_top dut (.clk_in, .resetn_in, .bus_resetn_in, .shared_addr_data_in,
		.shared_addr_data_out, .shared_addr_data_oe_out, .cbe_n_in,
		.frame_n_in, .irdy_n_in, .trdy_n_out, .trdy_oe_out, .devsel_n_out,
		.devsel_oe_out, .event_in, .host_interrupt_line_out,
		.host_interrupt_line_oe_out);
	hbr_host host (.clk_in, .ad_out(shared_addr_data_in),
		.cbe_n_out(cbe_n_in), .frame_n_out(frame_n_in),
		.irdy_n_out(irdy_n_in), .ad_in(shared_addr_data_out),
		.ad_oe_in(shared_addr_data_oe_out), .trdy_n_in(trdy_n_out));
	task automatic chk(input logic [AD_W-1:0] got, input logic [AD_W-1:0] e);
		n_checks++;
		if (got !== e) begin
			n_fail++;
			$display("wrong value at %0t: %h %h", $time, got, e);
		end
	endtask : chk
	task automatic chk_b(input logic got, input logic e);
		chk({31'h0, got}, {31'h0, e});
	endtask : chk_b
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	task automatic acc(input logic wr, input logic [IDX_W-1:0] i,
		input logic [AD_W-1:0] d, input int w);
		host.xfer(wr, {BASE_HI, 4'h0, i, 2'h0}, d, w, q, ok);
		chk_b(ok, 1'b1);
	endtask : acc
	task automatic rd_chk(input logic [IDX_W-1:0] i, input logic [AD_W-1:0] e);
		acc(1'b0, i, '0, 2);
		chk(q, e);
	endtask : rd_chk
	task automatic pulse(input int which);
		@(posedge clk_in);
		#2;
		if (which == 0) bus_resetn_in = 1'b0;
		if (which == 1) resetn_in = 1'b0;
		event_in = 1'b1;
		@(negedge clk_in);
		chk_b(trdy_oe_out | devsel_oe_out | shared_addr_data_oe_out
			| host_interrupt_line_oe_out, 1'b0);
		@(posedge clk_in);
		#2;
		bus_resetn_in = 1'b1;
		resetn_in = 1'b1;
		event_in = 1'b0;
	endtask : pulse
	task automatic t_access;
		acc(1'b1, IDX_PM, 32'hA5A50F0F, 0);
		acc(1'b1, IDX_VEND, 32'h12345678, 0);
		rd_chk(IDX_PM, 32'hA5A50F0F);
		host.xfer(1'b0, 32'h00000000, '0, 0, q, ok);
		chk_b(ok, 1'b0);
	endtask : t_access
	task automatic t_irq;
		acc(1'b1, IDX_CTRL, 32'h00000001, 0);
		pulse(2);
		chk_b(host_interrupt_line_oe_out, 1'b1);
		acc(1'b1, IDX_STAT, 32'h00000001, 0);
		chk_b(host_interrupt_line_oe_out, 1'b0);
	endtask : t_irq
	task automatic t_resets;
		pulse(2);
		chk_b(host_interrupt_line_oe_out, 1'b1);
		pulse(0);
		chk_b(host_interrupt_line_oe_out, 1'b0);
		rd_chk(IDX_CTRL, CTRL_RST);
		rd_chk(IDX_STAT, 32'h00000000);
		rd_chk(IDX_VEND, 32'h12345678);
		rd_chk(IDX_PM, 32'hA5A50F0F);
		acc(1'b1, IDX_CTRL, 32'h00000001, 0);
		pulse(2);
		chk_b(host_interrupt_line_oe_out, 1'b1);
		pulse(1);
		chk_b(host_interrupt_line_oe_out, 1'b0);
		rd_chk(IDX_PM, PM_RST);
		rd_chk(IDX_VEND, VEND_RST);
		rd_chk(IDX_STAT, 32'h00000000);
		rd_chk(IDX_CTRL, CTRL_RST);
	endtask : t_resets
	initial begin
		resetn_in = 1'b0;
		bus_resetn_in = 1'b0;
		event_in = 1'b0;
		repeat (8) @(posedge clk_in);
		#2;
		resetn_in = 1'b1;
		bus_resetn_in = 1'b1;
		t_access();
		t_irq();
		t_resets();
		finish_test();
	end
endmodule : tb_hbr_top
`default_nettype wire
